// ---- core/lcd_host_regs.vh ----
// Register indices, field positions, reset values and scan limits
// for the grey-scale panel host port. Included by the core files only.
`ifndef LCD_HOST_REGS_VH
`define LCD_HOST_REGS_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define IDX_CONTROL_ONE    5'h00
`define IDX_CONTROL_TWO    5'h01
`define IDX_COLUMN_ADDRESS 5'h02
`define IDX_ROW_ADDRESS    5'h03
`define IDX_MEMORY_PORT    5'h04
`define IDX_START_RASTER   5'h05
`define IDX_BLINK_FIRST    5'h06
`define IDX_BLINK_LAST     5'h07
`define IDX_BLINK_COLS_A   5'h08
`define IDX_BLINK_COLS_B   5'h09
`define IDX_BLINK_COLS_C   5'h0A
`define IDX_PARTIAL_POS    5'h0B
`define IDX_PALETTE_ONE    5'h0C
`define IDX_PALETTE_TWO    5'h0D
`define IDX_PALETTE_THREE  5'h0E
`define IDX_PALETTE_FOUR   5'h0F
`define IDX_CONTRAST       5'h10
`define IDX_WIDTH          5

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define BIT_MODIFY_IN_PLACE 7
`define BIT_PANEL_ON        6
`define BIT_SLEEP_CONTROL   5
`define BIT_SUPPLY_SWITCH   4
`define BIT_REVERSE         2
`define BIT_MIRROR          0
`define BIT_WORD_SIZE       5
`define BIT_STEP_AXIS       4
`define BIT_FLASH_AREA      3
`define BIT_FIXED_LEVEL     2
`define DUTY_MSB            1
`define DUTY_LSB            0

// ----------------------------------------
// Duty codes and scan limits
// ----------------------------------------
`define DUTY_80         2'h0
`define DUTY_64         2'h1
`define DUTY_32         2'h2
`define DUTY_PARTIAL    2'h3
`define LAST_RASTER_80  7'h4F
`define LAST_RASTER_64  7'h3F
`define LAST_RASTER_32  7'h1F
`define LAST_RASTER_8   7'h07
`define ROW_COUNT       7'h50
`define ROW_LAST        7'h4F
`define ROW_WRAP_MASK   7'h7F
`define COL_LAST_WIDE   6'h27
`define COL_LAST_NARROW 6'h35
`define COL_FIRST       6'h00
`define NARROW_MASK     8'h3F
`define PWM_LAST_PAL    5'h1E
`define PWM_LAST_FIXED  5'h02
`define BLINK_FRAMES    6'h3F
`define BLOCK_ROWS      7'h08
`define BLOCK_LAST_ROW  7'h07
`define BLOCK_LOWER_END 4'h5
`define BLOCK_UPPER_TOP 7'h48
`define CONTRAST_MSB    2

// ----------------------------------------
// Palette reset values
// ----------------------------------------
`define PALETTE_ONE_RESET   5'h00
`define PALETTE_TWO_RESET   5'h0B
`define PALETTE_THREE_RESET 5'h17
`define PALETTE_FOUR_RESET  5'h1F

`endif

// ---- core/lcd_display_ram.v ----
// Display RAM: flip-flop storage with one synchronous port.
// Assumes the caller arbitrates; read data lags the address one cycle.
`timescale 1ns/1ps
`default_nettype none

module lcd_display_ram #(
  parameter ADDR_W = 13,
  parameter DEPTH  = 4320,
  parameter WIDTH  = 8
) (
  input  wire              clk_sys,
  input  wire              writeEnable,
  input  wire [ADDR_W-1:0] address,
  input  wire [WIDTH-1:0]  writeData,
  output reg  [WIDTH-1:0]  readData
);

  // No reset: contents survive reset and sleep
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk_sys)
  begin
    if (writeEnable)
    begin
      mem[address] <= writeData;
    end
    readData <= mem[address];
  end

endmodule // lcd_display_ram

`default_nettype wire

// ---- core/lcd_host_ctrl.v ----
// Host index/data port, display RAM arbitration and panel scan engine.
// Assumes host pins are asynchronous to clk_sys and held several cycles.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_host_regs.vh"

module lcd_host_ctrl #(
  parameter COLS   = 54,
  parameter ROWS   = 80,
  parameter ADDR_W = 13
) (
  input  wire       clk_sys,
  input  wire       reset,
  input  wire       chipSelectN,
  input  wire       registerSelect,
  input  wire       writeN,
  input  wire       readN,
  input  wire [7:0] dataIn,
  output reg  [7:0] dataOut,
  output wire       dataOutEnableN,
  output wire       supplySwitchOutput,
  output wire       driversAtSupply,
  output wire       partialActive,
  output wire [2:0] partialContrast,
  output reg        scanValid,
  output reg  [6:0] rowDriverIndex,
  output reg  [5:0] columnWord,
  output reg  [3:0] columnDriverOn
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg  [11:0] pinMeta;
  reg  [11:0] pinSync;
  wire        selHost = ~pinSync[11];
  wire        selData = pinSync[10];
  wire        wrLevel = pinSync[9];
  wire        rdLevel = pinSync[8];
  wire [7:0]  busData = pinSync[7:0];

  always @(posedge clk_sys)
  begin
    pinMeta <= {chipSelectN, registerSelect, writeN, readN, dataIn};
    pinSync <= pinMeta;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [4:0]  indexReg;
  reg [7:0]  controlOne;
  reg [7:0]  controlTwo;
  reg [5:0]  columnAddress;
  reg [6:0]  rowAddress;
  reg [6:0]  startRaster;
  reg [6:0]  blinkFirst;
  reg [6:0]  blinkLast;
  reg [23:0] blinkColumns;
  reg [3:0]  blockPosition;
  reg [4:0]  palette [0:3];
  reg [7:0]  contrastLevel;
  reg [7:0]  readBuffer;

  wire       modifyInPlace = controlOne[`BIT_MODIFY_IN_PLACE];
  wire       sleepControl  = controlOne[`BIT_SLEEP_CONTROL];
  wire       mirror        = controlOne[`BIT_MIRROR];
  wire       wordNarrow    = controlTwo[`BIT_WORD_SIZE];
  wire       stepAxis      = controlTwo[`BIT_STEP_AXIS];
  wire       fixedLevel    = controlTwo[`BIT_FIXED_LEVEL];
  wire [1:0] dutySelect    = controlTwo[`DUTY_MSB:`DUTY_LSB];
  wire [5:0] colLast       = wordNarrow ? `COL_LAST_NARROW : `COL_LAST_WIDE;

  // ----------------------------------------
  // Strobe detection
  // ----------------------------------------
  reg       wrPrev;
  reg       rdPrev;
  reg [7:0] wrHoldData;
  reg       wrHoldData_sel;
  reg       wrHoldSelect;

  // Bus values are taken while the strobe is low; commit on its release
  wire wrDone   = wrLevel & ~wrPrev & wrHoldSelect;
  // index cycle when select is low, data cycle when high
  wire idxWrite = wrDone & ~wrHoldData_sel;
  wire regWrite = wrDone & wrHoldData_sel;
  wire rdStart  = ~rdLevel & rdPrev & selHost & selData;

  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      wrPrev         <= 1'b1;
      rdPrev         <= 1'b1;
      wrHoldData     <= 8'h00;
      wrHoldData_sel <= 1'b0;
      wrHoldSelect   <= 1'b0;
    end
    else
    begin
      wrPrev <= wrLevel;
      rdPrev <= rdLevel;
      if (!wrLevel)
      begin
        wrHoldData     <= busData;
        wrHoldData_sel <= selData;
        wrHoldSelect   <= selHost;
      end
    end
  end

  // ----------------------------------------
  // Memory port decode
  // ----------------------------------------
  // only the port index reaches the RAM; column and row set its address
  wire atPort    = indexReg == `IDX_MEMORY_PORT;
  wire portWrite = regWrite & atPort & ~sleepControl;
  wire portRead  = rdStart & atPort & ~sleepControl;
  // rows above the last real row are not stored or fetched
  wire rowReal   = rowAddress <= `ROW_LAST;
  wire hostWrite = portWrite & rowReal;
  wire hostRead  = portRead & rowReal;
  wire advance   = portWrite | (portRead & ~modifyInPlace);
  wire [7:0] storeData = wordNarrow ? (wrHoldData & `NARROW_MASK) : wrHoldData;

  function [ADDR_W-1:0] ramIndex;
    input [6:0] row;
    input [5:0] col;
    reg   [ADDR_W-1:0] colsW;
    begin
      colsW    = COLS[ADDR_W-1:0];
      ramIndex = row * colsW + col;
    end
  endfunction

  // ----------------------------------------
  // Register writes and address stepping
  // ----------------------------------------
  integer i;

  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      indexReg      <= 5'h00;
      controlOne    <= 8'h00;
      controlTwo    <= 8'h00;
      columnAddress <= `COL_FIRST;
      rowAddress    <= 7'h00;
      startRaster   <= 7'h00;
      blinkFirst    <= 7'h00;
      blinkLast     <= 7'h00;
      blinkColumns  <= 24'h000000;
      blockPosition <= 4'h0;
      palette[0]    <= `PALETTE_ONE_RESET;
      palette[1]    <= `PALETTE_TWO_RESET;
      palette[2]    <= `PALETTE_THREE_RESET;
      palette[3]    <= `PALETTE_FOUR_RESET;
      contrastLevel <= 8'h00;
    end
    else
    begin
      // index held until the next index write
      if (idxWrite)
      begin
        indexReg <= wrHoldData[`IDX_WIDTH-1:0];
      end
      // write-only registers; unused bits simply dropped
      if (regWrite)
      begin
        if (indexReg == `IDX_CONTROL_ONE)
          controlOne <= wrHoldData;
        else if (indexReg == `IDX_CONTROL_TWO)
          controlTwo <= wrHoldData;
        else if (indexReg == `IDX_COLUMN_ADDRESS)
          columnAddress <= wrHoldData[5:0];
        else if (indexReg == `IDX_ROW_ADDRESS)
          rowAddress <= wrHoldData[6:0];
        else if (indexReg == `IDX_START_RASTER)
          startRaster <= wrHoldData[6:0];
        else if (indexReg == `IDX_BLINK_FIRST)
          blinkFirst <= wrHoldData[6:0];
        else if (indexReg == `IDX_BLINK_LAST)
          blinkLast <= wrHoldData[6:0];
        else if (indexReg == `IDX_BLINK_COLS_A)
          blinkColumns[7:0] <= wrHoldData;
        else if (indexReg == `IDX_BLINK_COLS_B)
          blinkColumns[15:8] <= wrHoldData;
        else if (indexReg == `IDX_BLINK_COLS_C)
          blinkColumns[23:16] <= wrHoldData;
        else if (indexReg == `IDX_PARTIAL_POS)
          blockPosition <= wrHoldData[3:0];
        else if (indexReg == `IDX_CONTRAST)
          contrastLevel <= wrHoldData;
        else
        begin
          for (i = 0; i < 4; i = i + 1)
          begin
            if (indexReg == `IDX_PALETTE_ONE + i[4:0])
              palette[i] <= wrHoldData[4:0];
          end
        end
      end
      // panel on is the one bit not kept across sleep
      // Host write in the same cycle wins, so leaving sleep keeps panel on
      if (sleepControl && !(regWrite && indexReg == `IDX_CONTROL_ONE))
      begin
        controlOne[`BIT_PANEL_ON] <= 1'b0;
      end
      if (advance)
      begin
        // column steps and wraps at the word-size limit
        if (stepAxis)
          columnAddress <= (columnAddress == colLast) ? `COL_FIRST : columnAddress + 6'h01;
        // row steps through the full 7-bit range
        else
          rowAddress <= (rowAddress + 7'h01) & `ROW_WRAP_MASK;
      end
    end
  end

  // ----------------------------------------
  // RAM arbitration
  // ----------------------------------------
  wire [7:0]        ramData;
  wire              hostOp   = hostWrite | hostRead;
  wire              scanGo;
  wire [6:0]        scanRow;
  reg  [5:0]        scanCol;
  // host owns the port in its cycle; refresh waits one cycle
  wire [ADDR_W-1:0] ramAddr  = hostOp ? ramIndex(rowAddress, columnAddress) : ramIndex(scanRow, scanCol);
  reg               hostReadPend;

  lcd_display_ram #(
    .ADDR_W (ADDR_W),
    .DEPTH  (ROWS * COLS),
    .WIDTH  (8)
  ) displayRam (
    .clk_sys     (clk_sys),
    .writeEnable (hostWrite),
    .address     (ramAddr),
    .writeData   (storeData),
    .readData    (ramData)
  );

  // present the older byte, then capture the newly addressed one
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      dataOut      <= 8'h00;
      readBuffer   <= 8'h00;
      hostReadPend <= 1'b0;
    end
    else
    begin
      hostReadPend <= hostRead;
      if (portRead)
        dataOut <= readBuffer;
      if (hostReadPend)
        readBuffer <= ramData;
    end
  end

  assign dataOutEnableN = ~(selHost & ~rdLevel);

  // ----------------------------------------
  // Scan geometry
  // ----------------------------------------
  function [6:0] lastRaster;
    input [1:0] duty;
    begin
      case (duty)
        `DUTY_80: lastRaster = `LAST_RASTER_80;
        `DUTY_64: lastRaster = `LAST_RASTER_64;
        `DUTY_32: lastRaster = `LAST_RASTER_32;
        default:  lastRaster = `LAST_RASTER_8;
      endcase
    end
  endfunction

  function [6:0] driverFor;
    input [6:0] raster;
    input [1:0] duty;
    input       mir;
    input [3:0] block;
    reg   [6:0] half;
    reg   [6:0] base;
    reg         ascend;
    begin
      half   = (lastRaster(duty) >> 1) + 7'h01;
      base   = 7'h00;
      ascend = 1'b0;
      if (duty == `DUTY_PARTIAL)
      begin
        // lower blocks from the top, upper blocks from the bottom
        if (block < `BLOCK_LOWER_END)
        begin
          base   = {3'h0, block} * `BLOCK_ROWS;
          ascend = mir;
        end
        else
        begin
          base   = `BLOCK_UPPER_TOP - {3'h0, block - `BLOCK_LOWER_END} * `BLOCK_ROWS;
          ascend = ~mir;
        end
        // Stale raster after a duty change must not leave the block
        driverFor = ascend ? base + {4'h0, raster[2:0]} : base + `BLOCK_LAST_ROW - {4'h0, raster[2:0]};
      end
      else if (!mir)
        driverFor = (raster < half) ? raster : `ROW_LAST - (raster - half);
      else
        driverFor = (raster < half) ? (`ROW_COUNT - half) + raster : (half - 7'h01) - (raster - half);
    end
  endfunction

  function [6:0] wrapRow;
    input [6:0] a;
    input [6:0] b;
    reg   [7:0] sum;
    begin
      sum     = {1'b0, a} + {1'b0, b};
      wrapRow = (sum >= {1'b0, `ROW_COUNT}) ? sum[6:0] - `ROW_COUNT : sum[6:0];
    end
  endfunction

  // ----------------------------------------
  // Scan counters
  // ----------------------------------------
  reg  [4:0] scanPhase;
  reg  [6:0] scanRaster;
  reg  [5:0] frameCount;
  reg        blinkDark;
  wire [4:0] phaseLast = fixedLevel ? `PWM_LAST_FIXED : `PWM_LAST_PAL;
  wire [6:0] scanDriver = driverFor(scanRaster, dutySelect, mirror, blockPosition);
  // scroll by start raster, wrapping over the real rows
  // short duties keep stepping through consecutive RAM rows
  assign scanRow = (dutySelect == `DUTY_PARTIAL) ? scanDriver : wrapRow(startRaster, scanRaster);
  assign scanGo  = ~hostOp & ~sleepControl;

  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      scanCol    <= `COL_FIRST;
      scanPhase  <= 5'h00;
      scanRaster <= 7'h00;
      frameCount <= 6'h00;
      blinkDark  <= 1'b0;
    end
    else if (scanGo)
    begin
      scanCol <= (scanCol >= colLast) ? `COL_FIRST : scanCol + 6'h01;
      if (scanCol >= colLast)
      begin
        scanPhase <= (scanPhase >= phaseLast) ? 5'h00 : scanPhase + 5'h01;
        if (scanPhase >= phaseLast)
        begin
          scanRaster <= (scanRaster >= lastRaster(dutySelect)) ? 7'h00 : scanRaster + 7'h01;
          if (scanRaster >= lastRaster(dutySelect))
          begin
            frameCount <= frameCount + 6'h01;
            // flip the flash area once per 64 frames
            if (frameCount == `BLINK_FRAMES)
              blinkDark <= ~blinkDark;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Pixel output stage
  // ----------------------------------------
  reg       pendValid;
  reg [6:0] pendDriver;
  reg [6:0] pendRow;
  reg [5:0] pendCol;
  reg [4:0] pendPhase;

  function pixelOn;
    input [1:0] code;
    input [4:0] phase;
    input       fixed;
    input [4:0] level;
    begin
      // fixed mode on for code thirds of the line
      if (fixed)
        pixelOn = phase < {3'h0, code};
      // palette mode on for level of 31 phases
      else
        pixelOn = phase < level;
    end
  endfunction

  // rows between first and last, one column bit per two column words (8 dots wide, 6 narrow)
  // compared against the RAM row, so blink scrolls with content
  wire inBlink = controlTwo[`BIT_FLASH_AREA] & blinkDark
               & (pendRow >= blinkFirst) & (pendRow <= blinkLast)
               & blinkColumns[pendCol[5:1]];

  reg [3:0] next_columnOn;
  reg [1:0] code;
  integer   p;

  always @*
  begin
    next_columnOn = 4'h0;
    code          = 2'h0;
    for (p = 0; p < 4; p = p + 1)
    begin
      // odd bit is the high bit of each pixel pair
      if (wordNarrow)
        code = (p < 3) ? {ramData[5 - 2 * p], ramData[4 - 2 * p]} : 2'h0;
      else
        code = {ramData[7 - 2 * p], ramData[6 - 2 * p]};
      next_columnOn[3 - p] = (pixelOn(code, pendPhase, fixedLevel, palette[code])
                              ^ controlOne[`BIT_REVERSE]) & ~inBlink;
    end
  end

  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      pendValid      <= 1'b0;
      pendDriver     <= 7'h00;
      pendRow        <= 7'h00;
      pendCol        <= `COL_FIRST;
      pendPhase      <= 5'h00;
      scanValid      <= 1'b0;
      rowDriverIndex <= 7'h00;
      columnWord     <= `COL_FIRST;
      columnDriverOn <= 4'h0;
    end
    else
    begin
      pendValid  <= scanGo;
      pendDriver <= scanDriver;
      pendRow    <= scanRow;
      pendCol    <= scanCol;
      pendPhase  <= scanPhase;
      // partial mode scans only the selected eight rows
      scanValid  <= pendValid;
      if (pendValid)
      begin
        rowDriverIndex <= pendDriver;
        columnWord     <= pendCol;
        columnDriverOn <= next_columnOn;
      end
    end
  end

  // ----------------------------------------
  // Panel level outputs
  // ----------------------------------------
  // sleep or panel off holds every driver at the supply level
  assign driversAtSupply    = reset | sleepControl | ~controlOne[`BIT_PANEL_ON];
  assign supplySwitchOutput = controlOne[`BIT_SUPPLY_SWITCH];
  assign partialActive      = dutySelect == `DUTY_PARTIAL;
  // eight contrast steps from the low three bits
  assign partialContrast    = contrastLevel[`CONTRAST_MSB:0];

endmodule // lcd_host_ctrl

`default_nettype wire

// ---- sim/lcd_host_ctrl_sva.sv ----
// Assertion checker for the host port, top-level pins only.
// Assumes host strobes are held several cycles, as the bench does.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_ctrl_sva #(
  parameter COLS = 54,
  parameter ROWS = 80
) (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       chipSelectN,
  input wire logic       registerSelect,
  input wire logic       writeN,
  input wire logic       readN,
  input wire logic [7:0] dataIn,
  input wire logic [7:0] dataOut,
  input wire logic       dataOutEnableN,
  input wire logic       supplySwitchOutput,
  input wire logic       driversAtSupply,
  input wire logic       partialActive,
  input wire logic [2:0] partialContrast,
  input wire logic       scanValid,
  input wire logic [6:0] rowDriverIndex,
  input wire logic [5:0] columnWord,
  input wire logic [3:0] columnDriverOn
);
  // ------------------------------
  // Port properties
  // ------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence readStart;
    !chipSelectN && $fell(readN);
  endsequence
  sequence readIdle;
    readN[*4];
  endsequence
  sequence writeIdle;
    writeN[*6];
  endsequence
  AST_OE_READ: assert property (readStart |-> ##[1:3] !dataOutEnableN)
    else $error("output enable missing after read");
  AST_OE_IDLE: assert property (readIdle |-> dataOutEnableN)
    else $error("output enabled without read");
  AST_CS_IDLE: assert property (chipSelectN[*4] |-> dataOutEnableN)
    else $error("output enabled while deselected");
  AST_DOUT_CAUSE: assert property ($changed(dataOut) |-> !dataOutEnableN && $past(dataOutEnableN, 2))
    else $error("read data changed outside a read");
  AST_DOUT_HOLD: assert property (readIdle |-> $stable(dataOut))
    else $error("read data changed while idle");
  AST_OFF_AFTER_RESET: assert property ($fell(reset) |-> driversAtSupply)
    else $error("drivers active after reset");
  AST_CFG_HOLD: assert property (writeIdle |-> $stable({partialContrast, partialActive, supplySwitchOutput}))
    else $error("setting changed without write");
  AST_PANEL_HOLD: assert property (writeIdle |-> $stable(driversAtSupply))
    else $error("panel state changed without write");
  AST_ROW_RANGE: assert property (scanValid |-> rowDriverIndex < ROWS)
    else $error("row driver out of range");
  AST_COL_RANGE: assert property (scanValid |-> columnWord < COLS)
    else $error("column word out of range");
endmodule // lcd_host_ctrl_sva
bind lcd_host_ctrl lcd_host_ctrl_sva #(.COLS(COLS), .ROWS(ROWS)) lcd_host_ctrl_sva_i (
  .clk_sys(clk_sys), .reset(reset), .chipSelectN(chipSelectN), .registerSelect(registerSelect),
  .writeN(writeN), .readN(readN), .dataIn(dataIn), .dataOut(dataOut), .dataOutEnableN(dataOutEnableN),
  .supplySwitchOutput(supplySwitchOutput), .driversAtSupply(driversAtSupply), .partialActive(partialActive),
  .partialContrast(partialContrast), .scanValid(scanValid), .rowDriverIndex(rowDriverIndex),
  .columnWord(columnWord), .columnDriverOn(columnDriverOn));
`default_nettype wire

// ---- sim/lcd_host_mpu.sv ----
// Host processor model: index/data port strobes.
// Assumes the bench clock; drives only on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_mpu (
  input  wire logic       clk_sys,
  output var  logic       chipSelectN,
  output var  logic       registerSelect,
  output var  logic       writeN,
  output var  logic       readN,
  output var  logic [7:0] dataIn
);
  initial
  begin
    chipSelectN = 1'b1;
    registerSelect = 1'b0;
    writeN = 1'b1;
    readN = 1'b1;
    dataIn = 8'hA5;
  end
  task automatic access(input logic rs, input logic wr, input logic [7:0] d);
    @(negedge clk_sys);
    chipSelectN = 1'b0;
    registerSelect = rs;
    dataIn = d;
    @(negedge clk_sys);
    writeN = !wr;
    readN = wr;
    repeat (4) @(negedge clk_sys);
    writeN = 1'b1;
    readN = 1'b1;
    // Data held past release, then no stale value
    repeat (4) @(negedge clk_sys);
    chipSelectN = 1'b1;
    dataIn = ~d;
    repeat (4) @(negedge clk_sys);
  endtask
endmodule // lcd_host_mpu
`default_nettype wire

// ---- sim/lcd_ram_host_access_display_ctrl_test.sv ----
// Self-checking bench for the host port and panel control.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module lcd_ram_host_access_display_ctrl_test;
  logic            clk_sys = 1'b0;
  logic            reset = 1'b1;
  wire logic       chipSelectN, registerSelect, writeN, readN;
  wire logic [7:0] dataIn, dataOut;
  wire logic       dataOutEnableN, supplySwitchOutput, driversAtSupply, partialActive, scanValid;
  wire logic [2:0] partialContrast;
  wire logic [6:0] rowDriverIndex;
  wire logic [5:0] columnWord;
  wire logic [3:0] columnDriverOn;
  int              mismatches = 0;
  int              checks = 0;
  int              hits = 0;
  logic [15:0]     expQueue[$];
  logic [15:0]     e;
  logic [7:0]      d[3], m, v, k8, lo;
  always #5 clk_sys = ~clk_sys;
  lcd_host_mpu lcd_host_mpu_i (.clk_sys(clk_sys), .chipSelectN(chipSelectN), .registerSelect(registerSelect),
    .writeN(writeN), .readN(readN), .dataIn(dataIn));
  lcd_host_ctrl lcd_host_ctrl_i (.clk_sys(clk_sys), .reset(reset), .chipSelectN(chipSelectN),
    .registerSelect(registerSelect), .writeN(writeN), .readN(readN), .dataIn(dataIn), .dataOut(dataOut),
    .dataOutEnableN(dataOutEnableN), .supplySwitchOutput(supplySwitchOutput), .driversAtSupply(driversAtSupply),
    .partialActive(partialActive), .partialContrast(partialContrast), .scanValid(scanValid),
    .rowDriverIndex(rowDriverIndex), .columnWord(columnWord), .columnDriverOn(columnDriverOn));
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic check(input logic [7:0] act, input logic [7:0] exp);
    checks++;
    if (act !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [7:0] val);
    lcd_host_mpu_i.access(1'b0, 1'b1, idx);
    lcd_host_mpu_i.access(1'b1, 1'b1, val);
  endtask
  task automatic wmem(input logic [7:0] val);
    lcd_host_mpu_i.access(1'b1, 1'b1, val);
  endtask
  // Dummy reads use a zero mask
  task automatic rmem(input logic [7:0] mask, input logic [7:0] val);
    expQueue.push_back({mask, val});
    lcd_host_mpu_i.access(1'b1, 1'b0, 8'($urandom));
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ------------------------------
  // Read monitor and watchdog
  // ------------------------------
  always @(negedge dataOutEnableN)
  begin
    // Read data is loaded one edge after the enable falls
    repeat (2) @(negedge clk_sys);
    if (reset === 1'b0)
    begin
      e = expQueue.pop_front();
      check(dataOut & e[15:8], e[7:0]);
    end
  end
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    mismatches++;
    print_verdict();
  end
  // ------------------------------
  // Scenarios
  // ------------------------------
  initial
  begin
    void'($urandom(32'h832a2f2b));
    repeat (12) @(negedge clk_sys);
    check({7'h00, driversAtSupply}, 8'h01);
    reset = 1'b0;
    repeat (4) @(negedge clk_sys);
    m = 8'($urandom_range(76));
    foreach (d[i]) d[i] = 8'($urandom);
    wreg(8'h02, 8'($urandom_range(39)));
    wreg(8'h03, m);
    lcd_host_mpu_i.access(1'b0, 1'b1, 8'h04);
    foreach (d[i]) wmem(d[i]);
    wreg(8'h03, m);
    lcd_host_mpu_i.access(1'b0, 1'b1, 8'h04);
    rmem(8'h00, 8'h00);
    foreach (d[i]) rmem(8'hFF, d[i]);
    // Last real row, then writes past it
    wreg(8'h03, 8'h4F);
    lcd_host_mpu_i.access(1'b0, 1'b1, 8'h04);
    wmem(d[0]);
    wmem(d[1]);
    wreg(8'h03, 8'h4F);
    lcd_host_mpu_i.access(1'b0, 1'b1, 8'h04);
    rmem(8'h00, 8'h00);
    rmem(8'hFF, d[0]);
    rmem(8'hFF, d[0]);
    for (int k = 0; k < 2; k++)
    begin
      v = k ? 8'h35 : 8'h27;
      k8 = k ? 8'h3F : 8'hFF;
      wreg(8'h01, k ? 8'h30 : 8'h10);
      wreg(8'h02, v);
      wreg(8'h03, m);
      lcd_host_mpu_i.access(1'b0, 1'b1, 8'h04);
      wmem(d[1]);
      wmem(d[2]);
      wreg(8'h02, v);
      lcd_host_mpu_i.access(1'b0, 1'b1, 8'h04);
      rmem(8'h00, 8'h00);
      rmem(k8, d[1] & k8);
      rmem(k8, d[2] & k8);
    end
    wreg(8'h01, 8'h00);
    wreg(8'h00, 8'h80);
    wreg(8'h02, 8'h00);
    wreg(8'h03, m);
    lcd_host_mpu_i.access(1'b0, 1'b1, 8'h04);
    rmem(8'h00, 8'h00);
    rmem(8'h3F, d[2] & 8'h3F);
    rmem(8'h3F, d[2] & 8'h3F);
    wmem(d[0]);
    wmem(d[1]);
    wreg(8'h03, m);
    lcd_host_mpu_i.access(1'b0, 1'b1, 8'h04);
    rmem(8'h00, 8'h00);
    rmem(8'hFF, d[0]);
    wreg(8'h00, 8'h40);
    check({7'h00, driversAtSupply}, 8'h00);
    wreg(8'h00, 8'h60);
    check({7'h00, driversAtSupply}, 8'h01);
    wreg(8'h00, 8'h50);
    check({7'h00, driversAtSupply}, 8'h00);
    check({7'h00, supplySwitchOutput}, 8'h01);
    // Entry order for the low-power view
    wreg(8'h00, 8'h40);
    wreg(8'h01, 8'h07);
    wreg(8'h00, 8'h41);
    v = 8'($urandom_range(9));
    wreg(8'h0B, v);
    wreg(8'h05, 8'h00);
    k8 = 8'($urandom_range(7));
    wreg(8'h10, k8);
    check({7'h00, partialActive}, 8'h01);
    check({5'h00, partialContrast}, k8);
    lo = (v < 8'h05) ? 8'(v * 8) : 8'(8'h48 - (v - 8'h05) * 8);
    // Codes 00 and 11 only, so the pixel does not depend on the phase
    k8 = 8'($urandom_range(15));
    m = {{2{k8[3]}}, {2{k8[2]}}, {2{k8[1]}}, {2{k8[0]}}};
    wreg(8'h02, 8'h00);
    wreg(8'h03, lo);
    lcd_host_mpu_i.access(1'b0, 1'b1, 8'h04);
    wmem(m);
    repeat (1200)
    begin
      @(negedge clk_sys);
      if (scanValid === 1'b1)
        check({7'h00, rowDriverIndex >= lo[6:0] && rowDriverIndex <= lo[6:0] + 7'h07}, 8'h01);
      if (scanValid === 1'b1 && rowDriverIndex == lo[6:0] && columnWord == 6'h00)
      begin
        hits++;
        check({4'h0, columnDriverOn}, k8);
      end
    end
    check({7'h00, hits > 0}, 8'h01);
    check({7'h00, scanValid}, 8'h01);
    print_verdict();
  end
endmodule // lcd_ram_host_access_display_ctrl_test
`default_nettype wire
